// File: core/rtc_spi_device.sv
// Slave end: framing, bit timing, address counter, memory and power-fail lockout
`timescale 1ns/1ps
module rtc_spi_device #(
    parameter int unsigned RECOVERY_CYCLES = rtc_spi_pkg::RECOVERY_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial link
    rtc_spi_if.device       link,
    // Supply monitor
    input  wire logic       power_fail,
    output logic            write_protect,
    // Clock copy control
    output logic            clock_update_hold
);
    localparam int unsigned AW = rtc_spi_pkg::ADDR_BITS;

    generate
        if (RECOVERY_CYCLES < 1)
        begin : g_bad_rec
            $error("RECOVERY_CYCLES must be at least one");
        end
        if (rtc_spi_pkg::MEM_WORDS != (1 << AW))
        begin : g_bad_mem
            $error("MEM_WORDS must match the address width");
        end
    endgenerate

    logic [7:0]               mem [rtc_spi_pkg::MEM_WORDS];
    rtc_spi_pkg::dev_state_t  state;
    logic                     scl_q;
    logic                     cs_q;
    logic [31:0]              rec_cnt;
    logic [2:0]               bit_cnt;
    logic [2:0]               out_cnt;
    logic [6:0]               shift;
    logic [AW-1:0]            addr;
    logic                     sdo_out;
    logic                     sdo_oe_n;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     cs_fall;
    logic [7:0]               in_byte;
    logic                     wr_done;

    // Pointer step: the six-bit counter wraps from the top location to zero
    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
        return a + AW'(1);
    endfunction

    // Last of the eight clocks that make up one byte
    function automatic logic byte_end(input logic [2:0] n);
        return n == rtc_spi_pkg::LAST_BIT;
    endfunction

    assign scl_rise = link.scl & ~scl_q;
    assign scl_fall = ~link.scl & scl_q;
    assign cs_fall  = cs_q & ~link.cs_n;
    assign in_byte  = {shift, link.serial_data_in};                       // [RL16]
    assign wr_done  = (state == rtc_spi_pkg::DEV_WR) && !link.cs_n && !power_fail
                      && scl_rise && byte_end(bit_cnt);

    assign link.sdo_out  = sdo_out;
    assign link.sdo_oe_n = sdo_oe_n;

    // Select resets low so a select already low at start-up is not a start
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_q <= 1'b0;
            cs_q  <= 1'b0;                                      // [RL14]
        end
        else
        begin
            scl_q <= link.scl;
            cs_q  <= link.cs_n;
        end
    end

    // Recovery interval after the supply comes back
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rec_cnt       <= 32'h0;
            write_protect <= 1'b0;
        end
        else
        begin
            if (power_fail)
                rec_cnt <= RECOVERY_CYCLES;                     // [RL3]
            else if (rec_cnt != 32'h0)
                rec_cnt <= rec_cnt - 32'h1;                     // [RL3]
            write_protect <= power_fail || (rec_cnt > 32'h1);
        end
    end

    // Transfer framing and address counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state   <= rtc_spi_pkg::DEV_IDLE;
            bit_cnt <= 3'h0;
            out_cnt <= 3'h0;
            shift   <= 7'h0;
            addr    <= '0;
        end
        else if (power_fail)
        begin
            state   <= rtc_spi_pkg::DEV_IDLE;                   // [RL1] [RL2]
            addr    <= '0;                                      // [RL1]
            bit_cnt <= 3'h0;
        end
        else if (link.cs_n)
        begin
            state   <= rtc_spi_pkg::DEV_IDLE;                   // [RL10] [RL13] [RL20]
            bit_cnt <= 3'h0;
        end
        else if (cs_fall)
        begin
            // A start during recovery is dropped: whole frame stays locked out
            if (!write_protect)
                state <= rtc_spi_pkg::DEV_CMD;                  // [RL3] [RL10] [RL14]
            bit_cnt <= 3'h0;
            out_cnt <= 3'h0;
        end
        else
        begin
            unique case (state)
                rtc_spi_pkg::DEV_IDLE:
                begin
                    bit_cnt <= 3'h0;
                end
                rtc_spi_pkg::DEV_CMD:
                begin
                    if (scl_rise)
                    begin
                        shift   <= in_byte[6:0];                // [RL5]
                        bit_cnt <= bit_cnt + 3'h1;              // [RL7]
                        if (byte_end(bit_cnt))
                        begin
                            // Bit 6 of the address is dropped here
                            addr    <= in_byte[AW-1:0];         // [RL9] [RL17]
                            out_cnt <= 3'h0;
                            state   <= in_byte[7] ? rtc_spi_pkg::DEV_WR
                                                  : rtc_spi_pkg::DEV_RD;  // [RL17]
                        end
                    end
                end
                rtc_spi_pkg::DEV_WR:
                begin
                    if (scl_rise)
                    begin
                        shift   <= in_byte[6:0];                // [RL5]
                        bit_cnt <= bit_cnt + 3'h1;              // [RL8]
                        if (byte_end(bit_cnt))
                            addr <= next_addr(addr);            // [RL18]
                    end
                end
                rtc_spi_pkg::DEV_RD:
                begin
                    if (scl_fall)
                    begin
                        out_cnt <= out_cnt + 3'h1;              // [RL7] [RL8]
                        if (byte_end(out_cnt))
                            addr <= next_addr(addr);            // [RL18]
                    end
                end
            endcase
        end
    end

    // Memory is written only when a whole byte arrived inside the frame
    always_ff @(posedge clk)
    begin
        if (wr_done)
            mem[addr] <= in_byte;                               // [RL8] [RL20]
    end

    // Output driver: floats until the command byte is complete
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sdo_out  <= 1'b0;
            sdo_oe_n <= 1'b1;
        end
        else if (link.cs_n || power_fail || state != rtc_spi_pkg::DEV_RD)
        begin
            sdo_oe_n <= 1'b1;                                   // [RL12] [RL15]
        end
        else if (scl_fall)
        begin
            sdo_oe_n <= 1'b0;                                   // [RL15]
            sdo_out  <= mem[addr][~out_cnt];                    // [RL6] [RL16]
        end
    end

    // Clock copies frozen while a selected read or write has the pointer on a clock location
    always_ff @(posedge clk)
    begin
        if (rst)
            clock_update_hold <= 1'b0;
        else
            clock_update_hold <= !link.cs_n && !power_fail
                && (state == rtc_spi_pkg::DEV_WR || state == rtc_spi_pkg::DEV_RD)
                && (addr < rtc_spi_pkg::CLOCK_LOCS);            // [RL19]
    end
endmodule

// File: core/rtc_spi_master.sv
// Master end with its receive FIFO: clock divider, framing and byte shifter
`timescale 1ns/1ps
module rtc_spi_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
        begin : g_bad_fifo
            $error("FIFO depth must be a power of two of at least two");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;

    assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = store[rd_ptr[PW-1:0]];

    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
            store[wr_ptr[PW-1:0]] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
                wr_ptr <= wr_ptr + (PW+1)'(1);
            if (out_valid && out_ready)
                rd_ptr <= rd_ptr + (PW+1)'(1);
        end
    end
endmodule

module rtc_spi_master #(
    parameter int unsigned HALF_CYCLES = rtc_spi_pkg::SCL_HALF_CYCLES,
    parameter int unsigned FIFO_DEPTH  = rtc_spi_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial link
    rtc_spi_if.master       link,
    // Clock mode: 0 idles low, 1 idles high
    input  wire logic       cpol,
    // Transfer request
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic       req_write,
    input  wire logic [6:0] req_addr,
    input  wire logic [7:0] req_count,
    // Write data
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Read data
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready
);
    generate
        if (HALF_CYCLES < rtc_spi_pkg::SCL_HALF_CYCLES || HALF_CYCLES > 65535)
        begin : g_bad_half
            $error("HALF_CYCLES too short for the serial clock limits");
        end
    endgenerate

    rtc_spi_pkg::mst_state_t state;
    logic [15:0]             div;
    logic                    tick;
    logic                    cs_n;
    logic                    scl;
    logic                    serial_data_in;
    logic                    wr_mode;
    logic                    is_cmd;
    logic                    half;
    logic [2:0]              bit_n;
    logic [7:0]              left;
    logic [7:0]              shift;
    logic [6:0]              rx_sh;
    logic                    push;
    logic [7:0]              push_data;
    logic                    fifo_in_ready;
    logic                    stall;

    assign link.cs_n = cs_n;
    assign link.scl  = scl;
    assign link.serial_data_in  = serial_data_in;
    assign tick      = div == 16'(HALF_CYCLES - 1);
    // Data byte waits for write data or for room to store the read byte
    assign stall     = !is_cmd && bit_n == 3'h0 && !half
                       && (wr_mode ? !tx_valid : !fifo_in_ready);

    rtc_spi_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Half-period enable for the serial clock
    always_ff @(posedge clk)
    begin
        if (rst || tick)
            div <= 16'h0;
        else
            div <= div + 16'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= rtc_spi_pkg::MST_IDLE;
            cs_n      <= 1'b1;
            scl       <= 1'b0;
            serial_data_in       <= 1'b0;
            req_ready <= 1'b0;
            tx_ready  <= 1'b0;
            push      <= 1'b0;
            push_data <= 8'h0;
            wr_mode   <= 1'b0;
            is_cmd    <= 1'b0;
            half      <= 1'b0;
            bit_n     <= 3'h0;
            left      <= 8'h0;
            shift     <= 8'h0;
            rx_sh     <= 7'h0;
        end
        else
        begin
            tx_ready <= 1'b0;
            push     <= 1'b0;
            unique case (state)
                rtc_spi_pkg::MST_IDLE:
                begin
                    cs_n      <= 1'b1;                          // [RL10]
                    scl       <= cpol;                          // [RL4] [RL11]
                    req_ready <= 1'b1;
                    if (req_valid && req_ready)
                    begin
                        req_ready <= 1'b0;
                        wr_mode   <= req_write;
                        shift     <= {req_write, req_addr};     // [RL17]
                        left      <= req_count;
                        is_cmd    <= 1'b1;
                        state     <= rtc_spi_pkg::MST_SEL;
                    end
                end
                rtc_spi_pkg::MST_SEL:
                begin
                    if (tick)
                    begin
                        cs_n  <= 1'b0;                          // [RL10] [RL14]
                        half  <= 1'b0;
                        bit_n <= 3'h0;
                        state <= rtc_spi_pkg::MST_BIT;
                    end
                end
                rtc_spi_pkg::MST_BIT:
                begin
                    if (tick && !stall)
                    begin
                        half <= ~half;
                        if (!half)
                        begin
                            scl <= 1'b0;                        // [RL4]
                            if (!is_cmd && wr_mode && bit_n == 3'h0)
                            begin
                                serial_data_in      <= tx_data[7];         // [RL16]
                                shift    <= {tx_data[6:0], 1'b0};
                                tx_ready <= 1'b1;
                            end
                            else
                            begin
                                serial_data_in   <= shift[7];              // [RL16]
                                shift <= {shift[6:0], 1'b0};
                            end
                        end
                        else
                        begin
                            scl   <= 1'b1;                      // [RL4] [RL7]
                            rx_sh <= {rx_sh[5:0], link.serial_data_out};
                            bit_n <= bit_n + 3'h1;
                            if (bit_n == rtc_spi_pkg::LAST_BIT)
                            begin
                                is_cmd <= 1'b0;                 // [RL8]
                                if (!is_cmd && !wr_mode)
                                begin
                                    push      <= 1'b1;
                                    push_data <= {rx_sh, link.serial_data_out};
                                end
                                if (!is_cmd)
                                    left <= left - 8'h1;
                                if (!is_cmd && left == 8'h0)
                                    state <= rtc_spi_pkg::MST_END;
                            end
                        end
                    end
                end
                rtc_spi_pkg::MST_END:
                begin
                    if (tick)
                    begin
                        scl   <= cpol;                          // [RL11]
                        state <= rtc_spi_pkg::MST_GAP;
                    end
                end
                rtc_spi_pkg::MST_GAP:
                begin
                    if (tick)
                    begin
                        cs_n  <= 1'b1;                          // [RL10]
                        state <= rtc_spi_pkg::MST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// File: pkg/rtc_spi_if.sv
// Four-wire serial link between the master end and the RTC slave port
`timescale 1ns/1ps
interface rtc_spi_if;
    logic cs_n;
    logic scl;
    logic serial_data_in;
    logic sdo_out;
    logic sdo_oe_n;
    logic serial_data_out;

    // Pull-up on the shared data-out wire when nobody drives it
    assign serial_data_out = sdo_oe_n ? 1'b1 : sdo_out;

    modport device (input cs_n, input scl, input serial_data_in, output sdo_out, output sdo_oe_n);
    modport master (output cs_n, output scl, output serial_data_in, input serial_data_out);
endinterface

// File: pkg/rtc_spi_pkg.sv
// Shared constants and types for the serial RTC slave port and its master
// Functional notes
// RL1 - Power fail aborts access, clears address
// RL2 - Ignore serial inputs while supply fails
// RL3 - Protect writes through recovery interval
// RL4 - Support clock modes zero and three
// RL5 - Capture input bits on rising clock
// RL6 - Change output only after falling clock
// RL7 - One clock per transferred bit
// RL8 - Eight clocks form one byte
// RL9 - Address bit six is ignored
// RL10 - Select low starts, select high ends
// RL11 - Master toggles clock only while shifting
// RL12 - Deselected output stays high impedance
// RL13 - Deselected device ignores clock and data
// RL14 - Need select falling edge after power-on
// RL15 - Read output floats until byte ready
// RL16 - Most significant bit first both ways
// RL17 - First bit direction, then seven address
// RL18 - Address increments per byte, wraps
// RL19 - Hold clock updates at clock addresses
// RL20 - Partial write byte is discarded
package rtc_spi_pkg;
    localparam int unsigned CLK_MHZ            = 40;
    localparam int unsigned SCL_MIN_PERIOD_NS  = 500;
    localparam int unsigned SCL_HALF_CYCLES    =
        (SCL_MIN_PERIOD_NS * CLK_MHZ + 1999) / 2000;
    localparam int unsigned RECOVERY_INTERVAL_US = 1000;
    localparam int unsigned RECOVERY_CYCLES    = RECOVERY_INTERVAL_US * CLK_MHZ;
    localparam int unsigned MEM_WORDS          = 64;
    localparam int unsigned ADDR_BITS          = 6;
    localparam int unsigned BYTE_BITS          = 8;
    localparam logic [5:0]  CLOCK_LOCS         = 6'h08;
    localparam logic [2:0]  LAST_BIT           = 3'h7;
    localparam int unsigned FIFO_DEPTH         = 8;

    typedef enum logic [3:0] {
        DEV_IDLE = 4'b0001,
        DEV_CMD  = 4'b0010,
        DEV_WR   = 4'b0100,
        DEV_RD   = 4'b1000
    } dev_state_t;

    typedef enum logic [4:0] {
        MST_IDLE = 5'b00001,
        MST_SEL  = 5'b00010,
        MST_BIT  = 5'b00100,
        MST_END  = 5'b01000,
        MST_GAP  = 5'b10000
    } mst_state_t;
endpackage

// File: tb/rtc_serial_slave_port_tb_top.sv
// Bench: master end and RTC slave port joined over the serial link
`timescale 1ns/1ps
module rtc_serial_slave_port_tb_top;
    logic       clk;
    logic       rst;
    logic       cpol;
    logic       power_fail;
    logic       write_protect;
    logic       clock_update_hold;
    logic       req_valid;
    logic       req_ready;
    logic       req_write;
    logic [6:0] req_addr;
    logic [7:0] req_count;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_ready;
    logic [7:0] mem [64];
    int         num_errors;
    int         checks;

    rtc_spi_if link ();
    rtc_spi_device #(.RECOVERY_CYCLES(20)) i_rtc_spi_device (
        .clk(clk), .rst(rst), .link(link), .power_fail(power_fail),
        .write_protect(write_protect), .clock_update_hold(clock_update_hold));
    rtc_spi_master i_rtc_spi_master (
        .clk(clk), .rst(rst), .link(link), .cpol(cpol), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_count(req_count), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
    rtc_spi_chk #(.RECOVERY_CYCLES(20)) i_rtc_spi_chk (
        .clk(clk), .rst(rst), .cs_n(link.cs_n), .scl(link.scl), .serial_data_in(link.serial_data_in),
        .sdo_out(link.sdo_out), .sdo_oe_n(link.sdo_oe_n), .power_fail(power_fail),
        .write_protect(write_protect), .clock_update_hold(clock_update_hold));

    always #12.5 clk = ~clk;

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, g, e);
        end
    endtask

    task automatic cmp_flag(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
        end
    endtask

    task automatic idle();
        @(posedge clk);
        while (req_ready !== 1'b1)
            @(posedge clk);
    endtask

    task automatic start(input logic w, input logic [6:0] a, input int n);
        req_write <= w;
        req_addr  <= a;
        req_count <= n[7:0] - 8'h1;
        req_valid <= 1'b1;
        idle();
        req_valid <= 1'b0;
    endtask

    // Expected memory is only updated where the write is meant to land
    task automatic wr(input logic [6:0] a, input int n, input logic [7:0] v, input bit upd);
        start(1'b1, a, n);
        for (int k = 0; k < n; k++)
        begin
            tx_data  <= v + k[7:0];
            tx_valid <= 1'b1;
            @(posedge clk);
            while (tx_ready !== 1'b1)
                @(posedge clk);
            if (upd)
                mem[a[5:0] + k[5:0]] = v + k[7:0];
        end
        tx_valid <= 1'b0;
        idle();
    endtask

    task automatic collect(input logic [6:0] a, input int n);
        rx_ready <= 1'b1;
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk);
            while (rx_valid !== 1'b1)
                @(posedge clk);
            cmp_byte(rx_data, mem[a[5:0] + k[5:0]]);
        end
        rx_ready <= 1'b0;
        idle();
    endtask

    task automatic conclude();
        $display("checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {cpol, power_fail, req_valid, req_write, tx_valid, rx_ready} = 6'h0;
        {req_addr, req_count, tx_data} = 23'h0;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        idle();
        // Mode zero, address bit six set, burst wrapping past the top
        wr(7'h7e, 3, 8'ha1, 1);
        start(1'b0, 7'h3e, 3);
        collect(7'h3e, 3);
        cmp_flag(link.sdo_oe_n, 1'b1);
        // Mode three, reading clock locations keeps the hold up
        cpol <= 1'b1;
        wr(7'h04, 4, 8'h5c, 1);
        start(1'b0, 7'h45, 3);
        repeat (250) @(posedge clk);
        cmp_flag(clock_update_hold, 1'b1);
        collect(7'h45, 3);
        // Receive FIFO fills while the user stalls, master holds the frame
        cpol <= 1'b0;
        wr(7'h10, 12, 8'h30, 1);
        start(1'b0, 7'h10, 12);
        repeat (2000) @(posedge clk);
        cmp_flag(link.cs_n, 1'b0);
        collect(7'h10, 12);
        // Power fail in mid-frame, then a write during recovery
        wr(7'h20, 1, 8'h77, 1);
        fork
            wr(7'h20, 1, 8'h00, 0);
            begin
                repeat (60) @(posedge clk);
                power_fail <= 1'b1;
                repeat (3) @(posedge clk);
                cmp_flag(write_protect, 1'b1);
            end
        join
        power_fail <= 1'b0;
        @(posedge clk);
        cmp_flag(write_protect, 1'b1);
        wr(7'h20, 1, 8'h11, 0);
        repeat (30) @(posedge clk);
        cmp_flag(write_protect, 1'b0);
        start(1'b0, 7'h20, 1);
        collect(7'h20, 1);
        wr(7'h21, 1, 8'h9e, 1);
        start(1'b0, 7'h21, 1);
        collect(7'h21, 1);
        conclude();
    end

    // Whole run needs about 10000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end
endmodule

// File: tb/rtc_spi_chk.sv
// Concurrent checks on the serial link, supply lockout and clock hold
`timescale 1ns/1ps
module rtc_spi_chk #(
    parameter int unsigned RECOVERY_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic cs_n,
    input wire logic scl,
    input wire logic serial_data_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    // Supply and clock hold
    input wire logic power_fail,
    input wire logic write_protect,
    input wire logic clock_update_hold
);
    logic        scl_q;
    logic        dir;
    logic [9:0]  rises;
    logic [15:0] wp_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    always_ff @(posedge clk)
        scl_q <= scl;

    // Counted straight off the pins, so the device's own lag never hides a slip
    always_ff @(posedge clk)
    begin
        if (rst || cs_n)
            rises <= 10'h0;
        else if (scl && !scl_q)
            rises <= rises + 10'h1;
        if (!cs_n && scl && !scl_q && rises == 10'h0)
            dir <= serial_data_in;
    end

    always_ff @(posedge clk)
    begin
        if (rst || power_fail || !write_protect)
            wp_cnt <= 16'h0;
        else
            wp_cnt <= wp_cnt + 16'h1;
    end

    sequence desel_s;
        cs_n [*4];
    endsequence
    sequence frame_end_s;
        $rose(cs_n) ##1 cs_n [*3];
    endsequence

    desel_float_a: assert property (desel_s |-> sdo_oe_n)
        else $error("data out driven while deselected");
    pf_float_a: assert property (power_fail [*4] |-> sdo_oe_n)
        else $error("data out driven during power fail");
    pf_protect_a: assert property (power_fail |=> write_protect)
        else $error("no write protect during power fail");
    recovery_hold_a: assert property ($fell(power_fail) |-> write_protect [*8])
        else $error("write protect dropped too early");
    recovery_len_a: assert property (wp_cnt <= RECOVERY_CYCLES + 2)
        else $error("write protect held too long");
    sdo_step_a: assert property (!sdo_oe_n && $changed(sdo_out) |-> !$past(scl))
        else $error("data out changed without a falling clock");
    read_float_a: assert property (!cs_n && rises < 10'h8 |-> sdo_oe_n)
        else $error("data out driven during command byte");
    write_float_a: assert property (!cs_n && dir && rises >= 10'h8 |-> sdo_oe_n)
        else $error("data out driven during write");
    byte_group_a: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    hold_free_a: assert property (frame_end_s |-> !clock_update_hold)
        else $error("clock hold kept after deselect");
endmodule
